/* File: shared/lwp_regs.svh */
// constants for the late-write pipelined memory port
`ifndef LWP_REGS_SVH
`define LWP_REGS_SVH

// array geometry
`define LWP_ADDR_W 20
`define LWP_BYTE_W 9
`define LWP_BYTES 2
`define LWP_DATA_W 18

// burst counter width and its wrap value
`define LWP_BURST_W 2
`define LWP_BURST_LAST 2'h3

// pipeline depth from command edge to data edge, in clock cycles
`define LWP_DATA_LATENCY 2

// reset values
`define LWP_RST_CNT 2'h0
`define LWP_RST_BW 2'h3
`define LWP_RST_DATA 18'h00000
`define LWP_RST_ADDR 20'h00000

`endif

/* File: shared/lwp_pkg.sv */
// types shared by the late-write pipelined memory port
`include "lwp_regs.svh"

package lwp_pkg;

   // operation carried by a burst and by each pipeline stage
   typedef enum logic [2:0] {
      LWP_OP_IDLE  = 3'b001,
      LWP_OP_READ  = 3'b010,
      LWP_OP_WRITE = 3'b100
   } lwp_op_t;

   // synchronous command pins sampled on the clock
   typedef struct packed {
      logic [`LWP_ADDR_W-1:0] addr;
      logic chip_sel_low_a;
      logic chip_sel_high;
      logic chip_sel_low_b;
      logic advance_or_load;
      logic read_not_write;
      logic byte_wr_a_n;
      logic byte_wr_b_n;
   } lwp_cmd_t;

   // one operation travelling down the data pipeline
   typedef struct packed {
      lwp_op_t op;
      logic [`LWP_ADDR_W-1:0] addr;
      logic [`LWP_BYTES-1:0] bw_n;
   } lwp_stage_t;

   // burst bookkeeping
   typedef struct packed {
      lwp_op_t op;
      logic [`LWP_ADDR_W-1:0] base;
      logic [`LWP_BURST_W-1:0] cnt;
   } lwp_burst_t;

   // whole register state of the port
   typedef struct packed {
      logic sleep_meta;
      logic sleep;
      logic order_meta;
      logic order;
      lwp_burst_t burst;
      lwp_stage_t s1;
      lwp_stage_t s2;
      logic drive;
      logic [`LWP_DATA_W-1:0] rdata;
   } lwp_state_t;

endpackage

/* File: logic/lwp_port.sv */
// late-write pipelined synchronous memory port with burst counter
`timescale 1ns/1ps
`include "lwp_regs.svh"

module lwp_port #(
   parameter int ADDR_W = `LWP_ADDR_W,
   parameter int DEPTH = 1 << `LWP_ADDR_W
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // synchronous command pins
   input wire lwp_pkg::lwp_cmd_t cmd,
   input wire logic clock_enable_n,
   // asynchronous and static pins
   input wire logic out_drive_enable_n,
   input wire logic burst_order_select,
   input wire logic sleep_request,
   // data pins split into in, out and enable
   input wire logic [`LWP_DATA_W-1:0] dq_in,
   output logic [`LWP_DATA_W-1:0] dq_out,
   output logic dq_oe_n
);
   import lwp_pkg::*;

   // index width of the storage actually built
   localparam int AW = $clog2(DEPTH);

   // geometry check: depth a power of two, no wider than the address
   initial begin
      if (ADDR_W != `LWP_ADDR_W || DEPTH < 4 || DEPTH > (1 << ADDR_W)
          || DEPTH != (1 << AW))
         $error("lwp_port: unsupported geometry");
   end

   lwp_state_t q; // registered state
   lwp_state_t next_q; // next state
   logic [`LWP_DATA_W-1:0] rd_word; // word at the second-stage address
   logic is_load; // load cycle
   logic sel_ok; // all three selects active
   logic [`LWP_BURST_W-1:0] next_cnt; // advanced counter
   logic [`LWP_BURST_W-1:0] low_bits; // burst address low bits
   logic [ADDR_W-1:0] cur_addr; // address of this cycle
   lwp_op_t load_op; // operation decoded on load
   logic run; // edge not held and not asleep
   logic [`LWP_BYTES-1:0] byte_we; // per-byte write strobes

   // command decode from the raw synchronous pins
   always_comb begin
      is_load = ~cmd.advance_or_load;
      // deselect when any select inactive
      sel_ok = ~cmd.chip_sel_low_a & cmd.chip_sel_high & ~cmd.chip_sel_low_b;
      if (!sel_ok) begin
         load_op = LWP_OP_IDLE;
      end else if (cmd.read_not_write) begin
         load_op = LWP_OP_READ;
      end else begin
         load_op = LWP_OP_WRITE;
      end
   end

   // burst counter and address sequence
   always_comb begin
      next_cnt = q.burst.cnt + 2'h1; // two-bit wrap
      if (q.order) begin
         low_bits = q.burst.base[1:0] ^ next_cnt; // interleaved
      end else begin
         low_bits = q.burst.base[1:0] + next_cnt; // linear
      end
      if (is_load) begin
         cur_addr = cmd.addr; // new external address
      end else begin
         cur_addr = {q.burst.base[ADDR_W-1:2], low_bits};
      end
   end

   // an edge does work only when not held and not asleep
   assign run = ~clock_enable_n & ~q.sleep;

   // next-state logic
   always_comb begin
      next_q = q;
      // two-flop synchronisers for the sleep request and burst order pins
      next_q.sleep_meta = sleep_request;
      next_q.sleep = q.sleep_meta;
      next_q.order_meta = burst_order_select;
      next_q.order = q.order_meta;
      if (q.sleep) begin
         // sleep drops pending work and deselects
         next_q.burst.op = LWP_OP_IDLE;
         next_q.s1.op = LWP_OP_IDLE;
         next_q.s2.op = LWP_OP_IDLE;
         next_q.drive = 1'b0;
      end else if (!clock_enable_n) begin
         // front stage: load or advance
         if (is_load) begin
            next_q.burst.op = load_op;
            next_q.burst.base = cmd.addr;
            next_q.burst.cnt = `LWP_RST_CNT;
            next_q.s1.op = load_op;
         end else begin
            // operation persists, counter advances
            next_q.burst.cnt = next_cnt;
            next_q.s1.op = q.burst.op;
         end
         next_q.s1.addr = cur_addr;
         // byte enables sampled each command and burst cycle
         next_q.s1.bw_n = {cmd.byte_wr_b_n, cmd.byte_wr_a_n};
         // second stage, then data edge
         next_q.s2 = q.s1;
         // drivers only for reads; writes turn them off
         next_q.drive = (q.s2.op == LWP_OP_READ);
         if (q.s2.op == LWP_OP_READ) begin
            next_q.rdata = rd_word;
         end
      end
      // held edge keeps everything but the two-flop synchronisers as it was
   end

   // state register; pins released from reset
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         q <= '{sleep_meta: 1'b0, sleep: 1'b0,
                order_meta: 1'b1, order: 1'b1,
                burst: '{LWP_OP_IDLE, `LWP_RST_ADDR, `LWP_RST_CNT},
                s1: '{LWP_OP_IDLE, `LWP_RST_ADDR, `LWP_RST_BW},
                s2: '{LWP_OP_IDLE, `LWP_RST_ADDR, `LWP_RST_BW},
                drive: 1'b0, rdata: `LWP_RST_DATA};
      end else begin
         q <= next_q;
      end
   end

   // per-byte write into the array two cycles after the command
   genvar gb;
   generate
      for (gb = 0; gb < `LWP_BYTES; gb++) begin : g_byte
         // a byte is written only when its own enable is low
         assign byte_we[gb] = run & (q.s2.op == LWP_OP_WRITE)
                              & ~q.s2.bw_n[gb];
         // one bank per byte, so each byte has a single writer
         logic [`LWP_BYTE_W-1:0] bank [DEPTH];
         // read side of this byte's bank
         assign rd_word[gb*`LWP_BYTE_W +: `LWP_BYTE_W]
            = bank[q.s2.addr[AW-1:0]];
         // storage keeps its contents; no reset
         always_ff @(posedge clock) begin
            if (byte_we[gb]) begin
               bank[q.s2.addr[AW-1:0]]
                  <= dq_in[gb*`LWP_BYTE_W +: `LWP_BYTE_W];
            end
         end
      end
   endgenerate

   // pins: data from flops, enable released at once by output enable
   assign dq_out = q.rdata;
   assign dq_oe_n = ~(q.drive & ~out_drive_enable_n);

   // held edge freezes the pipeline
   a_hold_freezes: assert property (@(posedge clock) disable iff (rst)
      (clock_enable_n && !q.sleep) |=> $stable(q.s2) && $stable(q.burst))
      else $error("held edge changed state");

   // read data driven two edges after a read load
   a_read_latency: assert property (@(posedge clock) disable iff (rst)
      (run && is_load && load_op == LWP_OP_READ) ##1 run ##1 run
      |=> q.drive)
      else $error("read data not driven after two cycles");

   // write command reaches the array exactly two edges later
   a_write_latency: assert property (@(posedge clock) disable iff (rst)
      (run && is_load && load_op == LWP_OP_WRITE
       && !(cmd.byte_wr_a_n && cmd.byte_wr_b_n)) ##1 run
      |=> run |-> (|byte_we))
      else $error("write not performed two cycles later");

   // pins never driven during writes or without output enable
   a_pins_gated: assert property (@(posedge clock) disable iff (rst)
      !dq_oe_n |-> (q.drive && !out_drive_enable_n
                    && $past(q.s2.op) != LWP_OP_WRITE))
      else $error("pins driven outside a read");

   // deselect followed by three running edges, the first an advance, leaves the pins idle
   a_deselect_idle: assert property (@(posedge clock) disable iff (rst)
      (run && is_load && !sel_ok) ##1 (run && !is_load) ##1 run
      ##1 run |=> dq_oe_n)
      else $error("pins driven after deselect");

   // counter wraps to zero after the fourth burst cycle
   a_burst_wrap: assert property (@(posedge clock) disable iff (rst)
      (run && !is_load && q.burst.cnt == `LWP_BURST_LAST)
      |=> q.burst.cnt == `LWP_RST_CNT)
      else $error("burst counter did not wrap");

   // advance keeps the operation and the upper address
   a_burst_keeps: assert property (@(posedge clock) disable iff (rst)
      (run && !is_load) |=> $stable(q.burst.op) && $stable(q.burst.base)
      && q.s1.addr[ADDR_W-1:2] == q.burst.base[ADDR_W-1:2])
      else $error("burst changed operation or upper bits");

   // interleaved order follows start xor count
   a_order_inter: assert property (@(posedge clock) disable iff (rst)
      (run && !is_load && q.order)
      |=> q.s1.addr[1:0] == (q.burst.base[1:0] ^ q.burst.cnt))
      else $error("interleaved order broken");

   // aborted writes touch no byte
   a_abort_nowrite: assert property (@(posedge clock) disable iff (rst)
      (q.s2.bw_n == `LWP_RST_BW) |-> (byte_we == '0))
      else $error("write with all byte enables high");

   // sleep releases the pins and kills the pipeline
   a_sleep_idle: assert property (@(posedge clock) disable iff (rst)
      q.sleep |=> dq_oe_n && q.s2.op == LWP_OP_IDLE)
      else $error("activity during sleep");

   // further checks of decode, ordering, pin release and write gating

   // linear order adds the count to the start bits
   a_order_linear: assert property (@(posedge clock)
      disable iff (rst) (run && !is_load && !q.order)
      |=> q.s1.addr[1:0] == q.burst.base[1:0] + q.burst.cnt)
      else $error("linear order broken");

   // a load takes the external address and restarts the count
   a_load_addr: assert property (@(posedge clock)
      disable iff (rst) (run && is_load)
      |=> q.s1.addr == $past(cmd.addr) && q.burst.cnt == `LWP_RST_CNT)
      else $error("load did not take the external address");

   // advance carries the burst operation into the pipeline
   a_burst_op: assert property (@(posedge clock)
      disable iff (rst) (run && !is_load) |=> q.s1.op == q.burst.op)
      else $error("advance lost the burst operation");

   // a deselect load starts nothing
   a_deselect_load: assert property (@(posedge clock)
      disable iff (rst) (run && is_load && !sel_ok)
      |=> q.s1.op == LWP_OP_IDLE && q.burst.op == LWP_OP_IDLE)
      else $error("deselect started an operation");

   // selected load with read high begins a read
   a_read_begin: assert property (@(posedge clock)
      disable iff (rst) (run && is_load && sel_ok && cmd.read_not_write)
      |=> q.s1.op == LWP_OP_READ)
      else $error("read not begun");

   // selected load with read low begins a write
   a_write_begin: assert property (@(posedge clock)
      disable iff (rst) (run && is_load && sel_ok && !cmd.read_not_write)
      |=> q.s1.op == LWP_OP_WRITE)
      else $error("write not begun");

   // a write at the data edge turns the drivers off
   a_write_undriven: assert property (@(posedge clock)
      disable iff (rst) (run && q.s2.op == LWP_OP_WRITE) |=> !q.drive)
      else $error("drivers on during write");

   // held edge keeps the pins and read data as they were
   a_hold_keeps: assert property (@(posedge clock)
      disable iff (rst) (clock_enable_n && !q.sleep)
      |=> $stable(q.drive) && $stable(q.rdata))
      else $error("held edge changed the pins");

   // held edge writes nothing
   a_hold_nowrite: assert property (@(posedge clock)
      disable iff (rst) clock_enable_n |-> (byte_we == '0))
      else $error("write on a held edge");

   // inactive output enable always releases the pins
   a_oe_release: assert property (@(posedge clock)
      disable iff (rst) out_drive_enable_n |-> dq_oe_n)
      else $error("pins driven without output enable");

   // pins stay released while reset holds
   a_reset_off: assert property (@(posedge clock)
      rst |-> dq_oe_n)
      else $error("pins driven during reset");

   // a byte strobe never fires with its own enable high
   a_byte_own: assert property (@(posedge clock)
      disable iff (rst) (byte_we & q.s2.bw_n) == '0)
      else $error("byte written without its enable");

   // sleep blocks every write into the array
   a_sleep_nowrite: assert property (@(posedge clock)
      disable iff (rst) q.sleep |-> (byte_we == '0))
      else $error("write during sleep");

endmodule // lwp_port

/* File: tb/lwp_bus_model.sv */
// controller-side write data driver with two-cycle late write
`timescale 1ns/1ps
`include "lwp_regs.svh"
module lwp_bus_model (
   // clock and hold
   input wire logic clock,
   input wire logic clock_enable_n,
   // write data handed over with each command
   input wire logic wr_valid,
   input wire logic [`LWP_DATA_W-1:0] wr_data,
   // data wire toward the port
   output logic [`LWP_DATA_W-1:0] dq_in
);
   logic [1:0] v; // valid per stage
   logic [`LWP_DATA_W-1:0] d1, d2, last; // stages, last driven
   // advance only on running rising edges
   always_ff @(posedge clock) begin
      if (!clock_enable_n) begin
         v <= {v[0], wr_valid};
         d1 <= wr_data;
         d2 <= d1;
      end
      if (v[1]) last <= d2;
   end
   // released wire shows the inverse of the last value
   assign dq_in = v[1] ? d2 : ~last;
endmodule // lwp_bus_model

/* File: tb/lwp_tb.sv */
// self-checking bench for the late-write memory port
`timescale 1ns/1ps
`include "lwp_regs.svh"
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin \
   mismatches++; $display("Error %s expected %h seen %h", n, e, s); end end
module tb;
   import lwp_pkg::*;
   typedef struct packed {
      logic oe; // expected dq_oe_n with output enable on
      logic ck; // compare read data
      logic [`LWP_DATA_W-1:0] d; // expected read data
   } lwp_ex_t;
   localparam lwp_ex_t OFF = '{1'b1, 1'b0, 18'h00000};
   localparam logic [2:0] DS [3] = '{3'h6, 3'h0, 3'h3}; // deselects
   logic clock = 1'b0;
   logic rst = 1'b1;
   lwp_cmd_t cmd;
   logic clock_enable_n = 1'b0;
   logic out_drive_enable_n = 1'b0;
   logic burst_order_select = 1'b0;
   logic sleep_request = 1'b0;
   logic bo = 1'b0, sl = 1'b0, we = 1'b0, dq_oe_n;
   logic [17:0] wd = 18'h00000, dq_in, dq_out;
   int mismatches = 0;
   int comparisons = 0;
   lwp_ex_t x [3]; // expectations by pipeline stage
   lwp_ex_t pend; // expectation of the command in flight
   logic [17:0] dat [4] = '{18'h3C0F1, 18'h0A5A5, 18'h2F00F, 18'h14321};
   logic [17:0] m [4]; // contents by low address bits
   lwp_port #(.DEPTH(1024)) dut (.clock(clock), .rst(rst), .cmd(cmd),
      .clock_enable_n(clock_enable_n),
      .out_drive_enable_n(out_drive_enable_n),
      .burst_order_select(burst_order_select),
      .sleep_request(sleep_request), .dq_in(dq_in), .dq_out(dq_out),
      .dq_oe_n(dq_oe_n));
   lwp_bus_model bus (.clock(clock), .clock_enable_n(clock_enable_n),
      .wr_valid(we), .wr_data(wd), .dq_in(dq_in));
   // clock at 100 MHz
   always #5 clock = ~clock;
   function automatic lwp_cmd_t mk(logic [19:0] a, logic [2:0] cs,
      logic adv, logic rnw, logic [1:0] bw);
      return '{a, cs[2], cs[1], cs[0], adv, rnw, bw[0], bw[1]};
   endfunction
   // one clock: drive a command, check the one two running edges back
   task automatic cyc(lwp_cmd_t c, lwp_ex_t e, logic h = 1'b0,
      logic o = 1'b0, logic w = 1'b0, logic [17:0] dw = 18'h00000);
      @(posedge clock);
      if (!clock_enable_n) begin
         x[2] = x[1];
         x[1] = x[0];
         x[0] = pend;
      end
      pend = e;
      cmd <= c;
      clock_enable_n <= h;
      out_drive_enable_n <= o;
      we <= w;
      wd <= dw;
      burst_order_select <= bo;
      sleep_request <= sl;
      #1;
      `CHK("dq_oe_n", x[2].oe | o, dq_oe_n)
      if (x[2].ck && !o) `CHK("dq_out", x[2].d, dq_out)
   endtask
   // read burst; advances carry junk address, selects and direction
   task automatic rburst(logic [1:0] s, logic il, logic o);
      logic [1:0] lo;
      for (int k = 0; k < 4; k++) begin
         lo = il ? s ^ k[1:0] : s + k[1:0];
         cyc(mk(k ? 20'hFFFFF : {18'h00004, s}, k ? 3'h5 : 3'h2, k != 0,
            k == 0, 2'h3), '{1'b0, 1'b1, m[lo]}, 1'b0, o);
         if (k == 2 && !o) cyc(cmd, OFF, 1'b1, o);
      end
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // watchdog well beyond the fewer than fifty cycles of the run
   initial begin
      repeat (2000) @(posedge clock);
      mismatches++;
      summarize();
   end
   // main sequence
   initial begin
      cmd = mk(20'h00000, 3'h6, 1'b0, 1'b1, 2'h3);
      pend = OFF;
      x = '{OFF, OFF, OFF};
      m = '{dat[3], dat[0], dat[1], {dat[2][17:9], 9'h1EE}};
      repeat (3) @(posedge clock);
      `CHK("dq_oe_n in reset", 1'b1, dq_oe_n)
      rst <= 1'b0;
      for (int k = 0; k < 4; k++)
         cyc(mk(k ? 20'hFFFFF : 20'h00011, k ? 3'h5 : 3'h2, k != 0, k != 0,
            2'h0), OFF, 1'b0, 1'b0, 1'b1, dat[k]);
      cyc(mk(20'h00013, 3'h2, 1'b0, 1'b0, 2'h2), OFF, 1'b0, 1'b0, 1'b1,
         18'h001EE);
      cyc(mk(20'h00012, 3'h2, 1'b0, 1'b0, 2'h3), OFF, 1'b0, 1'b0, 1'b1,
         18'h3FFFF);
      $display("test write done");
      rburst(2'h1, 1'b0, 1'b0);
      rburst(2'h1, 1'b0, 1'b1);
      $display("test linear read done");
      bo = 1'b1;
      foreach (DS[i])
         cyc(mk(20'h00011, DS[i], 1'b0, 1'b1, 2'h3), OFF);
      cyc(mk(20'h00011, 3'h2, 1'b1, 1'b1, 2'h3), OFF);
      rburst(2'h1, 1'b1, 1'b0);
      $display("test interleaved read done");
      repeat (2) cyc(mk(20'h00011, 3'h6, 1'b0, 1'b1, 2'h3), OFF);
      sl = 1'b1;
      repeat (3) cyc(mk(20'h00011, 3'h6, 1'b0, 1'b1, 2'h3), OFF);
      repeat (4) cyc(mk(20'h00011, 3'h2, 1'b0, 1'b1, 2'h3), OFF);
      sl = 1'b0;
      repeat (3) cyc(mk(20'h00011, 3'h6, 1'b0, 1'b1, 2'h3), OFF);
      rburst(2'h1, 1'b1, 1'b0);
      repeat (3) cyc(mk(20'h00011, 3'h6, 1'b0, 1'b1, 2'h3), OFF);
      $display("test sleep done");
      summarize();
   end
endmodule // tb
